// >>> cdec_core.sv
// decoder and sequencer for hi-register, pc-relative and register-offset forms
// Functional notes
// - reading r15 gives instruction address plus four, bit 0 cleared
// - hi-register add and move leave the flags untouched
// - hi-register compare sets flags from first minus second
// - branch-exchange target bit 0 clear enters 32-bit state
// - branch-exchange target bit 0 set enters compressed state
// - pc-relative load reads one word at pc plus scaled offset
// - eight-bit offset field scaled by four to a ten-bit byte offset
// - pc-relative base is instruction address plus four, bit 1 cleared
// - register-offset address is base plus offset, low registers only
// - direction bit 0 store 1 load; size bit 0 word 1 byte
// - byte store writes only the low byte of the source
// - code 0,0 stores low halfword at base plus offset
// - code 0,1 loads halfword and clears upper bits
// - code 1,0 loads byte and sign-extends from bit 7
// - code 1,1 loads halfword and sign-extends from bit 15
// - cycle counts match the equivalent 32-bit-state instructions
// - only hi-register opcode 01 updates the flags
`default_nettype none
`include "cdec_regs.svh"
module cdec_core (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [31:0] instr_addr,
  output logic instr_ready,
  output logic [3:0] rd_idx_a,
  output logic [3:0] rd_idx_b,
  output logic [3:0] rd_idx_c,
  input wire logic [31:0] rd_data_a,
  input wire logic [31:0] rd_data_b,
  input wire logic [31:0] rd_data_c,
  output cdec_pkg::mem_req_t mem_req,
  input wire logic [31:0] mem_rdata,
  output cdec_pkg::reg_wr_t reg_wr,
  output cdec_pkg::flags_t status_word_flags,
  output logic compressed_state,
  output logic branch_taken,
  output logic [31:0] branch_target,
  output logic undefined_op
);
  import cdec_pkg::*;

  typedef enum logic [1:0] {st_idle, st_mem, st_wait, st_wb} state_t;
  typedef struct packed {
    state_t st;
    mem_req_t mem;
    reg_wr_t wr;
    flags_t flags;
    logic cstate;
    logic br;
    logic [31:0] tgt;
    logic undef;
    logic [3:0] dest;
    size_t lsize;
    logic lsign;
    logic [2:0] cnt;
  } core_t;

  core_t s_q;
  core_t s_d;
  logic [31:0] op_a;
  logic [31:0] op_b;
  logic [31:0] op_c;
  logic [31:0] load_val;
  logic [32:0] diff;
  logic is_fmt5;
  logic is_fmt6;
  logic is_fmt7;
  logic [1:0] op5;
  logic [3:0] hd;
  logic [3:0] hs;

  // field extraction, four-bit hi-register numbers
  assign is_fmt5 = instr[15:10] == `FMT5_TOP;
  assign is_fmt6 = instr[15:11] == `FMT6_TOP;
  assign is_fmt7 = instr[15:12] == `FMT7_TOP;
  assign op5 = instr[9:8];
  assign hd = {instr[7], instr[2:0]};
  assign hs = {instr[6], instr[5:3]};

  // register port indices depend on the format
  always_comb begin
    rd_idx_a = {1'b0, instr[5:3]}; // base register
    rd_idx_b = {1'b0, instr[8:6]}; // offset register
    rd_idx_c = {1'b0, instr[2:0]}; // store source
    if (is_fmt5) begin
      rd_idx_a = hd;
      rd_idx_b = hs;
    end
  end

  // operand views, r15 reads pc plus four
  cdec_operand u_opa (.idx(rd_idx_a), .reg_value(rd_data_a), .instr_addr(instr_addr),
    .value(op_a));
  cdec_operand u_opb (.idx(rd_idx_b), .reg_value(rd_data_b), .instr_addr(instr_addr),
    .value(op_b));
  cdec_operand u_opc (.idx(rd_idx_c), .reg_value(rd_data_c), .instr_addr(instr_addr),
    .value(op_c));

  cdec_load_align u_align (.size(s_q.lsize), .sign_ext(s_q.lsign), .rdata(mem_rdata),
    .value(load_val));

  assign diff = {1'b0, op_a} + {1'b0, ~op_b} + 33'h0_0000_0001;
  assign instr_ready = s_q.st == st_idle;

  // next-state logic of the whole sequencer
  always_comb begin
    s_d = s_q;
    s_d.wr.we = 1'b0;
    s_d.br = 1'b0;
    s_d.undef = 1'b0;
    unique case (s_q.st)
      st_idle: begin
        s_d.mem.req = 1'b0;
        if (instr_valid) begin
          if (is_fmt5) begin
            unique case (op5)
              `HIREG_OP_ADD: begin
                // flags untouched
                s_d.wr = '{we: 1'b1, idx: hd, data: op_a + op_b};
                s_d.undef = ~(instr[7] | instr[6]);
              end
              `HIREG_OP_COMPARE: begin
                // only compare sets flags
                s_d.flags.n = diff[31];
                s_d.flags.z = diff[31:0] == 32'h0000_0000;
                s_d.flags.c = diff[32];
                s_d.flags.v = (op_a[31] ^ op_b[31]) & (op_a[31] ^ diff[31]);
                s_d.undef = ~(instr[7] | instr[6]);
              end
              `HIREG_OP_MOV: begin
                s_d.wr = '{we: 1'b1, idx: hd, data: op_b};
                s_d.undef = ~(instr[7] | instr[6]);
              end
              default: begin
                // branch-exchange, bit 0 picks the state
                s_d.br = 1'b1;
                s_d.cstate = op_b[0];
                s_d.tgt = {op_b[31:1], 1'b0};
                s_d.undef = instr[7];
              end
            endcase
            if (s_d.wr.we && hd == `PC_REG) begin
              s_d.br = 1'b1;
              s_d.tgt = {s_d.wr.data[31:1], 1'b0};
              s_d.wr.we = 1'b0;
            end
          end else if (is_fmt6) begin
            // word-aligned pc plus scaled field
            s_d.mem.req = 1'b1;
            s_d.mem.write = 1'b0;
            s_d.mem.size = size_word;
            s_d.mem.addr = ((instr_addr + `PC_AHEAD) & ~32'h0000_0002)
              + {22'h000000, instr[7:0], 2'h0};
            s_d.dest = {1'b0, instr[10:8]};
            s_d.lsize = size_word;
            s_d.lsign = 1'b0;
            s_d.cnt = `WORD_CYCLES_LOAD;
            s_d.st = st_mem;
          end else if (is_fmt7) begin
            s_d.mem.req = 1'b1;
            s_d.mem.addr = op_a + op_b;
            s_d.dest = {1'b0, instr[2:0]};
            s_d.mem.wdata = op_c;
            if (!instr[9]) begin
              // format 7: load/byte bits
              s_d.mem.write = ~instr[11];
              s_d.mem.size = instr[10] ? size_byte : size_word;
              if (instr[10]) begin
                s_d.mem.wdata = {24'h000000, op_c[7:0]};
              end
              s_d.lsign = 1'b0;
            end else begin
              // format 8: halfword and sign-extended forms
              s_d.mem.write = ~(instr[11] | instr[10]);
              s_d.mem.size = (instr[11] & ~instr[10]) ? size_byte : size_half;
              s_d.mem.wdata = {16'h0000, op_c[15:0]};
              s_d.lsign = instr[11];
            end
            s_d.lsize = s_d.mem.size;
            s_d.cnt = s_d.mem.write ? `WORD_CYCLES_STORE : `WORD_CYCLES_LOAD;
            s_d.st = st_mem;
          end else begin
            s_d.undef = 1'b1;
          end
        end
      end
      st_mem: begin
        // address phase ends: request drops, read data come next cycle
        s_d.mem.req = 1'b0;
        s_d.cnt = s_q.cnt - 3'h1;
        s_d.st = st_wait;
      end
      st_wait: begin
        // pad to the 32-bit-state cycle count
        s_d.cnt = s_q.cnt - 3'h1;
        if (s_q.cnt == 3'h1) begin
          s_d.wr.we = ~s_q.mem.write;
          s_d.st = st_idle;
        end else if (s_q.cnt == 3'h2 && !s_q.mem.write) begin
          // read data stand only in this cycle, so capture them now
          s_d.wr = '{we: 1'b0, idx: s_q.dest, data: load_val};
          s_d.st = st_wb;
        end
      end
      st_wb: begin
        s_d.cnt = 3'h0;
        s_d.wr.we = 1'b1;
        s_d.st = st_idle;
      end
    endcase
  end

  // single state register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{st: st_idle, mem: '0, wr: '0, flags: '0, cstate: 1'b1, br: 1'b0,
        tgt: 32'h0000_0000, undef: 1'b0, dest: 4'h0, lsize: size_word, lsign: 1'b0,
        cnt: 3'h0};
    end else begin
      s_q <= s_d;
    end
  end

  assign mem_req = s_q.mem;
  assign reg_wr = s_q.wr;
  assign status_word_flags = s_q.flags;
  assign compressed_state = s_q.cstate;
  assign branch_taken = s_q.br;
  assign branch_target = s_q.tgt;
  assign undefined_op = s_q.undef;

  // checks on the decoder's own outputs and its r15 operand view, all on the core clock
  AST_PC_VIEW: assert property (@(posedge clock) disable iff (!rst_b)
    (rd_idx_a == `PC_REG) |-> (op_a == ((instr_addr + `PC_AHEAD) & ~32'h0000_0001)))
    else $error("pc operand view wrong");
  AST_FLAGS_HOLD: assert property (@(posedge clock) disable iff (!rst_b)
    (instr_ready && instr_valid && is_fmt5 && op5 != `HIREG_OP_COMPARE)
      |=> $stable(status_word_flags))
    else $error("flags changed by non-compare");
  AST_COMPARE_ZERO: assert property (@(posedge clock) disable iff (!rst_b)
    (instr_ready && instr_valid && is_fmt5 && op5 == `HIREG_OP_COMPARE && op_a == op_b)
      |=> status_word_flags.z && status_word_flags.c)
    else $error("compare of equal values did not set zero");
  AST_EXCHANGE_STATE: assert property (@(posedge clock) disable iff (!rst_b)
    (instr_ready && instr_valid && is_fmt5 && op5 == `HIREG_OP_EXCHANGE)
      |=> branch_taken && compressed_state == $past(op_b[0]))
    else $error("branch-exchange state wrong");
  AST_PCREL_ADDR: assert property (@(posedge clock) disable iff (!rst_b)
    (instr_ready && instr_valid && is_fmt6) |=> mem_req.req && !mem_req.write
      && mem_req.addr[1:0] == 2'h0)
    else $error("pc-relative address misaligned");
  AST_REGOFS_ADDR: assert property (@(posedge clock) disable iff (!rst_b)
    (instr_ready && instr_valid && is_fmt7) |=> mem_req.addr == $past(op_a + op_b))
    else $error("register-offset address wrong");
  AST_LOAD_CYCLES: assert property (@(posedge clock) disable iff (!rst_b)
    (instr_ready && instr_valid
      && (is_fmt6 || (is_fmt7 && (instr[11] || (instr[9] && instr[10])))))
      |=> !instr_ready [*3] ##1 instr_ready && reg_wr.we)
    else $error("load cycle count wrong");
  AST_STORE_CYCLES: assert property (@(posedge clock) disable iff (!rst_b)
    (instr_ready && instr_valid && is_fmt7 && !instr[11] && !(instr[9] && instr[10]))
      |=> !instr_ready [*2] ##1 instr_ready && !reg_wr.we)
    else $error("store cycle count wrong");
  AST_BYTE_STORE: assert property (@(posedge clock) disable iff (!rst_b)
    (mem_req.req && mem_req.write && mem_req.size == size_byte)
      |-> mem_req.wdata[31:8] == 24'h000000)
    else $error("byte store carries upper bits");

  // decode-wide guards on flags, branches and the data port
  AST_FLAGS_ONLY_COMPARE: assert property (@(posedge clock) disable iff (!rst_b)
    (instr_ready && instr_valid && !(is_fmt5 && op5 == `HIREG_OP_COMPARE))
      |=> $stable(status_word_flags))
    else $error("flags changed outside compare");
  AST_EXCHANGE_TARGET: assert property (@(posedge clock) disable iff (!rst_b)
    (instr_ready && instr_valid && is_fmt5 && op5 == `HIREG_OP_EXCHANGE)
      |=> branch_target == {$past(op_b[31:1]), 1'b0})
    else $error("branch-exchange target wrong");
  AST_PC_WRITE: assert property (@(posedge clock) disable iff (!rst_b)
    (instr_ready && instr_valid && is_fmt5 && op5 != `HIREG_OP_COMPARE
      && op5 != `HIREG_OP_EXCHANGE && hd == `PC_REG)
      |=> branch_taken && !reg_wr.we && $stable(compressed_state))
    else $error("write to r15 did not branch");
  AST_PCREL_WB: assert property (@(posedge clock) disable iff (!rst_b)
    (instr_ready && instr_valid && is_fmt6)
      |=> ##3 reg_wr.we && reg_wr.idx == {1'b0, $past(instr[10:8], 4)})
    else $error("pc-relative load wrote wrong register");
  AST_REGOFS_KIND: assert property (@(posedge clock) disable iff (!rst_b)
    (instr_ready && instr_valid && is_fmt7 && !instr[9])
      |=> mem_req.write == !$past(instr[11])
        && mem_req.size == ($past(instr[10]) ? size_byte : size_word))
    else $error("register-offset direction or size wrong");
  AST_SIGNED_BYTE_SIZE: assert property (@(posedge clock) disable iff (!rst_b)
    (instr_ready && instr_valid && is_fmt7 && instr[9] && instr[11] && !instr[10])
      |=> mem_req.size == size_byte && !mem_req.write)
    else $error("signed byte load has wrong size");
  AST_HALF_STORE: assert property (@(posedge clock) disable iff (!rst_b)
    (mem_req.req && mem_req.write && mem_req.size == size_half)
      |-> mem_req.wdata[31:16] == 16'h0000)
    else $error("halfword store carries upper bits");
  AST_REQ_PULSE: assert property (@(posedge clock) disable iff (!rst_b)
    mem_req.req |=> !mem_req.req)
    else $error("memory request longer than one cycle");
endmodule : cdec_core
`default_nettype wire

// >>> cdec_load_align.sv
// extends a loaded byte or halfword to a full register value
`default_nettype none
module cdec_load_align (
  input wire cdec_pkg::size_t size,
  input wire logic sign_ext,
  input wire logic [31:0] rdata,
  output logic [31:0] value
);
  import cdec_pkg::*;
  // zero or sign extension of the low lane
  always_comb begin
    unique case (size)
      size_byte: value = sign_ext ? {{24{rdata[7]}}, rdata[7:0]}
                                  : {24'h000000, rdata[7:0]};
      size_half: value = sign_ext ? {{16{rdata[15]}}, rdata[15:0]}
                                  : {16'h0000, rdata[15:0]};
      default: value = rdata;
    endcase
  end
endmodule : cdec_load_align
`default_nettype wire

// >>> cdec_operand.sv
// operand read port: register value, or the program counter view for r15
`default_nettype none
`include "cdec_regs.svh"
module cdec_operand (
  input wire logic [3:0] idx,
  input wire logic [31:0] reg_value,
  input wire logic [31:0] instr_addr,
  output logic [31:0] value
);
  // r15 reads as instruction address plus four, bit 0 cleared
  always_comb begin
    if (idx == `PC_REG) begin
      value = (instr_addr + `PC_AHEAD) & ~32'h0000_0001;
    end else begin
      value = reg_value;
    end
  end
endmodule : cdec_operand
`default_nettype wire

// >>> cdec_partner.sv
// register file and data memory model on the far side of the decoder
`default_nettype none
module cdec_partner (
  input wire logic clock,
  input wire logic [3:0] rd_idx_a,
  input wire logic [3:0] rd_idx_b,
  input wire logic [3:0] rd_idx_c,
  output logic [31:0] rd_data_a,
  output logic [31:0] rd_data_b,
  output logic [31:0] rd_data_c,
  input wire cdec_pkg::mem_req_t mem_req,
  output logic [31:0] mem_rdata,
  input wire cdec_pkg::reg_wr_t reg_wr
);
  import cdec_pkg::*;
  logic [31:0] regs [16];
  logic [31:0] next_rdata;
  logic [31:0] shown_q = 32'hA5A5_C3C3;
  // same-cycle reads; r15 holds junk that the decoder must not use
  assign rd_data_a = regs[rd_idx_a];
  assign rd_data_b = regs[rd_idx_b];
  assign rd_data_c = regs[rd_idx_c];
  assign mem_rdata = shown_q;
  // read data stand only in the cycle after a read, a toggling pattern otherwise
  always @(posedge clock) begin
    if (mem_req.req && !mem_req.write) begin
      shown_q <= next_rdata;
    end else begin
      shown_q <= ~shown_q;
    end
    if (reg_wr.we) begin
      regs[reg_wr.idx] <= reg_wr.data;
    end
  end
endmodule : cdec_partner
`default_nettype wire

// >>> cdec_pkg.sv
// types shared by the decoder, its load aligner, its partner model and the bench
`default_nettype none
package cdec_pkg;
  typedef enum logic [1:0] {size_word, size_half, size_byte} size_t;
  typedef struct packed {
    logic req;
    logic write;
    size_t size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_t;
  typedef struct packed {
    logic we;
    logic [3:0] idx;
    logic [31:0] data;
  } reg_wr_t;
  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } flags_t;
endpackage : cdec_pkg
`default_nettype wire

// >>> cdec_regs.svh
// constants for the compressed load/store and hi-register decoder
`ifndef CDEC_REGS_SVH
`define CDEC_REGS_SVH
`define PC_REG 4'hF
`define PC_AHEAD 32'h0000_0004
`define SCALE_SHIFT 2
`define HIREG_OP_ADD 2'h0
`define HIREG_OP_COMPARE 2'h1
`define HIREG_OP_MOV 2'h2
`define HIREG_OP_EXCHANGE 2'h3
`define FMT5_TOP 6'h11
`define FMT6_TOP 5'h09
`define FMT7_TOP 4'h5
`define WORD_CYCLES_LOAD 3'h3
`define WORD_CYCLES_STORE 3'h2
`endif

// >>> compressed_isa_load_store_decode_tb.sv
// self-checking bench for the compressed load/store and hi-register decoder
`default_nettype none
module compressed_isa_load_store_decode_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cdec_pkg::*;
  logic clock, rst_b, instr_valid, instr_ready, branch_taken, compressed_state, undefined_op;
  logic [15:0] instr;
  logic [31:0] instr_addr, rd_data_a, rd_data_b, rd_data_c, mem_rdata, branch_target;
  logic [31:0] pc, seed;
  logic [3:0] rd_idx_a, rd_idx_b, rd_idx_c;
  mem_req_t mem_req;
  reg_wr_t reg_wr;
  flags_t status_word_flags, m_fl;
  logic [31:0] m_reg [16];
  logic m_st;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc_cnt = 0;
  cdec_core u_cdec_core (.*);
  cdec_partner u_cdec_partner (.*);
  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end
  // xorshift source of stimulus
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // operand view: r15 reads as instruction address plus four, bit 0 clear
  function automatic logic [31:0] rv(input logic [3:0] n);
    return (n == 4'hF) ? ((pc + 32'h4) & ~32'h1) : m_reg[n];
  endfunction : rv
  task automatic final_report();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [38:0] got, input logic [38:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one instruction: model it, offer it, watch every pulse it makes
  task automatic run(input logic [15:0] i);
    logic [31:0] a, b, c, r, x, et;
    logic [3:0] d;
    mem_req_t em;
    reg_wr_t ew;
    size_t sz;
    logic eb, eu, gm, gw, gb, gu, ld;
    int cyc, rdy;
    x = rnd();
    u_cdec_partner.next_rdata = x;
    em = '0;
    ew = '0;
    eb = 1'h0;
    eu = 1'h0;
    et = 32'h0;
    cyc = 1;
    rdy = 0;
    d = {1'h0, i[2:0]};
    a = rv({1'h0, i[5:3]}) + rv({1'h0, i[8:6]});
    c = rv(d);
    if (i[15:10] == 6'h11) begin
      d = {i[7], i[2:0]};
      a = rv(d);
      b = rv({i[6], i[5:3]});
      r = (i[9:8] == 2'h2) ? b : a + b;
      if (i[9:8] == 2'h1) begin
        r = a - b;
        m_fl = {r[31], r == 32'h0, a >= b, (a[31] != b[31]) && (r[31] != a[31])};
      end else if (i[9:8] == 2'h3) begin
        eb = 1'h1;
        et = b & ~32'h1;
        m_st = b[0];
      end else if (d == 4'hF) begin
        eb = 1'h1;
        et = r & ~32'h1;
      end else begin
        ew = {1'h1, d, r};
      end
    end else if (i[15:11] == 5'h09) begin
      em = {1'h1, 1'h0, size_word, ((pc + 32'h4) & ~32'h2) + {22'h0, i[7:0], 2'h0}, 32'h0};
      ew = {1'h1, 1'h0, i[10:8], x};
      cyc = 4;
    end else if (i[15:12] != 4'h5) begin
      eu = 1'h1; // unknown format: undefined pulse and nothing else
    end else begin
      ld = i[9] ? (i[11:10] != 2'h0) : i[11];
      sz = i[9] ? ((i[11:10] == 2'h2) ? size_byte : size_half) : (i[10] ? size_byte : size_word);
      b = i[9] ? {16'h0, c[15:0]} : (i[10] ? {24'h0, c[7:0]} : c);
      em = {1'h1, ~ld, sz, a, b};
      case ({i[9], i[11:10]})
        3'h5: b = {16'h0, x[15:0]};
        3'h6: b = {{24{x[7]}}, x[7:0]};
        3'h7: b = {{16{x[15]}}, x[15:0]};
        default: b = i[10] ? {24'h0, x[7:0]} : x;
      endcase
      if (ld) begin
        ew = {1'h1, d, b};
      end
      cyc = ld ? 4 : 3;
    end
    instr <= i;
    instr_addr <= pc;
    instr_valid <= 1'h1;
    @(posedge clock);
    instr_valid <= 1'h0;
    gm = 1'h0;
    gw = 1'h0;
    gb = 1'h0;
    gu = 1'h0;
    for (int k = 1; k < 8; k++) begin
      #1;
      if (mem_req.req) begin
        gm = 1'h1;
        chk({mem_req.write, mem_req.size, mem_req.addr}, {em.write, em.size, em.addr});
        if (em.write) chk(mem_req.wdata, em.wdata);
      end
      if (reg_wr.we) begin
        gw = 1'h1;
        chk({reg_wr.idx, reg_wr.data}, {ew.idx, ew.data});
      end
      if (branch_taken) begin
        gb = 1'h1;
        chk(branch_target, et);
      end
      gu = gu | undefined_op;
      if (instr_ready && rdy == 0) rdy = k;
      @(posedge clock);
    end
    chk({gm, gw, gb, gu}, {em.req, ew.we, eb, eu});
    chk(rdy, cyc);
    chk(status_word_flags, m_fl);
    chk(compressed_state, m_st);
    if (ew.we) m_reg[ew.idx] = ew.data;
  endtask : run
  // cut a hung run short
  always @(posedge clock) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 30000) begin
      error_cnt++;
      $display("MISMATCH %0t timeout", $time);
      final_report();
    end
  end
  // reset, one boundary offset, then random instruction mix
  initial begin
    logic [31:0] r;
    logic [15:0] i;
    seed = 32'h0000_1822;
    rst_b = 1'h0;
    instr_valid = 1'h0;
    instr = 16'h0;
    instr_addr = 32'h0;
    pc = 32'h0000_0FFE;
    m_fl = '0;
    m_st = 1'h1;
    for (int k = 0; k < 16; k++) begin
      m_reg[k] = rnd();
      u_cdec_partner.regs[k] = m_reg[k];
    end
    repeat (12) @(posedge clock);
    rst_b <= 1'h1;
    chk(compressed_state, m_st);
    run({5'h09, 3'h1, 8'hFF});
    for (int k = 0; k < 400; k++) begin
      r = rnd();
      pc = rnd() & ~32'h1;
      case (r[14:12])
        3'h2: i = {5'h09, r[10:0]};
        3'h3, 3'h4: i = {4'h5, r[11:10], 1'h0, r[8:0]};
        3'h5, 3'h6: i = {4'h5, r[11:10], 1'h1, r[8:0]};
        3'h7: i = {6'h10, r[9:0]};
        default: begin
          i = {6'h11, r[9:0]};
          if (r[9:8] == 2'h3) i[7:0] = {1'h0, r[6:3], 3'h0};
          else if (r[7:6] == 2'h0) i[6] = 1'h1;
          if (r[9:8] == 2'h3 && i[6:3] == 4'hF && pc[1]) i[6] = 1'h0;
        end
      endcase
      run(i);
    end
    final_report();
  end
endmodule : compressed_isa_load_store_decode_tb
`default_nettype wire
